// File: line_tpg_defs.svh
`ifndef LINE_TPG_DEFS_SVH
`define LINE_TPG_DEFS_SVH

`define PIX_W 12
`define LCNT_W 12

`define REG_PATTERN 8'h00
`define REG_TRIG_CFG 8'h04
`define REG_LINE_LEN 8'h08
`define REG_DGAIN 8'h0C
`define REG_STATUS 8'h10
`define REG_LINES 8'h14

`define PAT_OFF 3'h0
`define PAT_FIX8 3'h1
`define PAT_MOV8 3'h2
`define PAT_MOV12 3'h3
`define PAT_FEAT8 3'h4
`define PAT_FEAT12 3'h5

`define TRIG_EXT_BIT 0
`define TRIG_SOFT_BIT 1
`define DGAIN_EN_BIT 16
`define STAT_BUSY_BIT 16
`define STAT_OVT_BIT 17
`define STAT_TRIG_BIT 18
`define STAT_FCNT_LSB 24

`define LINE_LEN_RST 16'h0800
`define DGAIN_RST 10'h100
`define DGAIN_FRAC 8
`define MAX8 12'h0FF
`define MAX12 12'hFFF

`endif

// File: line_tpg_pkg.sv
package line_tpg_pkg;

  typedef enum logic [0:0] {
    GS_IDLE,
    GS_RUN
  } gen_state_e;

endpackage : line_tpg_pkg

// File: stream_if.sv
`timescale 1ns/1ps
interface stream_if #(
  parameter int W = 13
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// File: pix_fifo.sv
`timescale 1ns/1ps
module pix_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic clock_i,
  input wire logic srst_i,
  stream_if.snk in_s,
  stream_if.src out_s,
  output logic [CNT_W-1:0] count_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  generate
    if (DEPTH < 4) begin : g_bad_depth
      $error("pix_fifo needs DEPTH of at least 4");
    end
  endgenerate

  typedef struct packed {
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] cnt;
  } fifo_s;

  fifo_s r_reg;
  fifo_s r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_s.ready = (r_reg.cnt != FULL_CNT);
  assign out_s.valid = (r_reg.cnt != '0);
  assign out_s.data = mem[r_reg.rd];
  assign count_o = r_reg.cnt;
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wr = bump(r_reg.wr);
    end
    if (pop) begin
      r_next.rd = bump(r_reg.rd);
    end
    if (push && !pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Storage needs no reset; valid comes from the count
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[r_reg.wr] <= in_s.data;
    end
  end

endmodule : pix_fifo

// File: line_tpg.sv
// Function
// - test mode discards sensor, generates every line
// - external trigger selected: one line per trigger
// - analog settings never reach generated pixels
// - patterns one to three bypass digital processing
// - feature patterns pass through digital gain
// - selector takes off or patterns one to five
// - writing off restores sensor line output
// - pattern one: column modulo 256
// - line counter increments on every line
// - pattern two: column plus counter, modulo 256
// - pattern three: column plus counter, modulo 4096
// - pattern four: pattern two through processing
// - pattern five: pattern three through processing
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "line_tpg_defs.svh"
module line_tpg
  import line_tpg_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int COL_W = 16
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_trig_i,
  input wire logic ext_trig_i,
  input wire logic sensor_valid_i,
  input wire logic [`PIX_W-1:0] sensor_data_i,
  input wire logic sensor_last_i,
  output logic sensor_ready_o,
  output logic px_valid_o,
  output logic [`PIX_W-1:0] px_data_o,
  output logic px_last_o,
  input wire logic px_ready_i,
  output logic test_active_o
);
  localparam int FW = `PIX_W + 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  generate
    if (COL_W < 8 || COL_W > 16) begin : g_bad_col
      $error("line_tpg needs COL_W between 8 and 16");
    end
    if (FIFO_DEPTH < 4) begin : g_bad_depth
      $error("line_tpg needs FIFO_DEPTH of at least 4");
    end
  endgenerate

  // Slack for the registered sensor ready and the processing stage
  localparam logic [CNT_W-1:0] ROOM_MAX = CNT_W'(FIFO_DEPTH - 3);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [2:0] pat;
    logic ext_sel;
    logic [COL_W-1:0] len;
    logic [9:0] gain;
    logic gain_en;
    logic ovt;
    logic soft_trig;
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    gen_state_e st;
    logic [2:0] lpat;
    logic [COL_W-1:0] col;
    logic [`LCNT_W-1:0] cnt;
    logic [31:0] lines;
    logic pv;
    logic [`PIX_W-1:0] pd;
    logic pl;
    logic sens_rdy;
    logic ov;
    logic [`PIX_W-1:0] od;
    logic ol;
  } state_s;

  state_s r_reg;
  state_s r_next;

  stream_if #(.W(FW)) fifo_in ();
  stream_if #(.W(FW)) fifo_out ();
  logic [CNT_W-1:0] fifo_cnt;

  pix_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .CNT_W(CNT_W)
  ) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_s(fifo_in.snk),
    .out_s(fifo_out.src),
    .count_o(fifo_cnt)
  );

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lane_merge = (old_v & ~m) | (new_v & m);
  endfunction : lane_merge

  // Digital gain stage with saturation at the pattern's bit depth
  function automatic logic [`PIX_W-1:0] dsp(
    input logic [`PIX_W-1:0] p,
    input logic en,
    input logic [9:0] g,
    input logic is8
  );
    logic [21:0] prod;
    logic [13:0] q;
    logic [`PIX_W-1:0] lim;
    prod = 22'(p) * 22'(g);
    q = prod[21:`DGAIN_FRAC];
    lim = is8 ? `MAX8 : `MAX12;
    if (!en) begin
      dsp = p;
    end else if (q > 14'(lim)) begin
      dsp = lim;
    end else begin
      dsp = q[`PIX_W-1:0];
    end
  endfunction : dsp

  logic req;
  logic wr_now;
  logic [31:0] wval;
  logic [31:0] rmux;
  logic ext_rise;
  logic trig;
  logic room;
  logic test_mode;
  logic emit;
  logic sens_take;
  logic [`LCNT_W-1:0] mov;
  logic [`PIX_W-1:0] gpix;
  logic glast;
  logic gproc;
  logic g8;
  logic ovt_set;
  logic ovt_clr;
  logic out_free;

  assign out_free = !r_reg.ov || px_ready_i;
  assign fifo_out.ready = out_free;
  assign fifo_in.valid = r_reg.pv;
  assign fifo_in.data = {r_reg.pl, r_reg.pd};

  always_comb begin
    r_next = r_reg;
    req = wb_cyc_i & wb_stb_i;
    wr_now = req & r_reg.ack & wb_we_i;
    rmux = 32'h0000_0000;
    wval = 32'h0000_0000;
    ovt_clr = 1'b0;
    ovt_set = 1'b0;
    r_next.soft_trig = 1'b0;

    // Bus reply one cycle after the request; writes land on the ack edge
    r_next.ack = req & !r_reg.ack;
    case (wb_adr_i[7:2])
      `REG_PATTERN >> 2: begin
        rmux = {29'h0, r_reg.pat};
      end
      `REG_TRIG_CFG >> 2: begin
        rmux = {31'h0, r_reg.ext_sel};
      end
      `REG_LINE_LEN >> 2: begin
        rmux = 32'(r_reg.len);
      end
      `REG_DGAIN >> 2: begin
        rmux = {15'h0, r_reg.gain_en, 6'h0, r_reg.gain};
      end
      `REG_STATUS >> 2: begin
        rmux = 32'(r_reg.cnt);
        rmux[`STAT_BUSY_BIT] = (r_reg.st == GS_RUN);
        rmux[`STAT_OVT_BIT] = r_reg.ovt;
        rmux[`STAT_TRIG_BIT] = r_reg.lvl;
        rmux[`STAT_FCNT_LSB +: 4] = 4'(fifo_cnt);
      end
      `REG_LINES >> 2: begin
        rmux = r_reg.lines;
      end
      default: begin
        rmux = 32'h0000_0000;
      end
    endcase
    if (req && !r_reg.ack) begin
      r_next.rdat = rmux;
    end

    if (wr_now) begin
      case (wb_adr_i[7:2])
        `REG_PATTERN >> 2: begin
          wval = lane_merge({29'h0, r_reg.pat}, wb_dat_i, wb_sel_i);
          if (wval[2:0] <= `PAT_FEAT12) begin
            r_next.pat = wval[2:0];
            if (wval[2:0] != `PAT_OFF && wval[2:0] != r_reg.pat) begin
              r_next.cnt = '0;
            end
          end
        end
        `REG_TRIG_CFG >> 2: begin
          wval = lane_merge({31'h0, r_reg.ext_sel}, wb_dat_i, wb_sel_i);
          r_next.ext_sel = wval[`TRIG_EXT_BIT];
          r_next.soft_trig = wval[`TRIG_SOFT_BIT];
        end
        `REG_LINE_LEN >> 2: begin
          wval = lane_merge(32'(r_reg.len), wb_dat_i, wb_sel_i);
          r_next.len = (wval[COL_W-1:0] == '0) ? COL_W'(1) : wval[COL_W-1:0];
        end
        `REG_DGAIN >> 2: begin
          wval = lane_merge({15'h0, r_reg.gain_en, 6'h0, r_reg.gain}, wb_dat_i, wb_sel_i);
          r_next.gain = wval[9:0];
          r_next.gain_en = wval[`DGAIN_EN_BIT];
        end
        `REG_STATUS >> 2: begin
          ovt_clr = wb_sel_i[2] & wb_dat_i[`STAT_OVT_BIT];
        end
        default: begin
        end
      endcase
    end

    // Trigger pin filter: a level counts once the last two stages agree
    r_next.s1 = ext_trig_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    ext_rise = 1'b0;
    if (r_reg.s2 == r_reg.s3 && r_reg.s3 != r_reg.lvl) begin
      r_next.lvl = r_reg.s3;
      ext_rise = r_reg.s3;
    end
    trig = r_reg.ext_sel ? ext_rise : (line_trig_i | r_reg.soft_trig);

    room = fifo_in.ready && (fifo_cnt <= ROOM_MAX);
    test_mode = (r_reg.pat != `PAT_OFF) || (r_reg.st == GS_RUN);

    mov = `LCNT_W'(r_reg.col) + r_reg.cnt;
    g8 = (r_reg.lpat != `PAT_MOV12) && (r_reg.lpat != `PAT_FEAT12);
    gproc = (r_reg.lpat == `PAT_FEAT8) || (r_reg.lpat == `PAT_FEAT12);
    glast = (r_reg.col == r_reg.len - 1'b1);
    case (r_reg.lpat)
      `PAT_FIX8: gpix = {4'h0, r_reg.col[7:0]};
      `PAT_MOV8, `PAT_FEAT8: gpix = {4'h0, mov[7:0]};
      `PAT_MOV12, `PAT_FEAT12: gpix = mov;
      default: gpix = '0;
    endcase

    emit = 1'b0;
    case (r_reg.st)
      GS_IDLE: begin
        if (trig && r_reg.pat != `PAT_OFF) begin
          r_next.st = GS_RUN;
          r_next.lpat = r_reg.pat;
          r_next.col = '0;
        end
      end
      GS_RUN: begin
        ovt_set = trig;
        if (room) begin
          emit = 1'b1;
          if (glast) begin
            r_next.st = GS_IDLE;
            r_next.cnt = r_reg.cnt + 1'b1;
            r_next.lines = r_reg.lines + 1'b1;
          end else begin
            r_next.col = r_reg.col + 1'b1;
          end
        end
      end
      default: begin
        r_next.st = GS_IDLE;
      end
    endcase
    // Set wins over a clear in the same cycle
    r_next.ovt = (r_reg.ovt & ~ovt_clr) | ovt_set;

    // In test mode sensor beats are drained and dropped
    sens_take = sensor_valid_i & r_reg.sens_rdy & !test_mode;
    r_next.sens_rdy = test_mode | room;

    // Sensor data carries the analog settings; generated data never does
    r_next.pv = emit | sens_take;
    if (emit) begin
      r_next.pd = gproc ? dsp(gpix, r_reg.gain_en, r_reg.gain, g8) : gpix;
      r_next.pl = glast;
    end else if (sens_take) begin
      r_next.pd = dsp(sensor_data_i, r_reg.gain_en, r_reg.gain, 1'b0);
      r_next.pl = sensor_last_i;
    end

    if (out_free) begin
      r_next.ov = fifo_out.valid;
      r_next.od = fifo_out.data[`PIX_W-1:0];
      r_next.ol = fifo_out.data[`PIX_W];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r_reg <= '0;
      r_reg.len <= COL_W'(`LINE_LEN_RST);
      r_reg.gain <= `DGAIN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.rdat;
  assign sensor_ready_o = r_reg.sens_rdy;
  assign px_valid_o = r_reg.ov;
  assign px_data_o = r_reg.od;
  assign px_last_o = r_reg.ol;
  assign test_active_o = r_reg.st == GS_RUN;

endmodule : line_tpg

// File: line_tpg_props.sv
`timescale 1ns/1ps
`include "line_tpg_defs.svh"
module line_tpg_props (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic px_valid_o,
  input wire logic [`PIX_W-1:0] px_data_o,
  input wire logic px_last_o,
  input wire logic px_ready_i,
  input wire logic sensor_ready_o,
  input wire logic test_active_o
);
  logic [2:0] pat_reg;
  logic [11:0] prev_reg;
  logic mid_reg;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire beat = px_valid_o & px_ready_i;
  // Tracks the selector so gradient steps are only judged in bypass patterns
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pat_reg <= 3'h0;
      mid_reg <= 1'b0;
      prev_reg <= 12'h000;
    end else begin
      if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && wb_dat_i[2:0] <= 3'h5)
        pat_reg <= wb_dat_i[2:0];
      if (beat) begin
        mid_reg <= ~px_last_o;
        prev_reg <= px_data_o;
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (req |=> wb_ack_o) else $error("no ack one cycle after request");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[7:2] > 6'h05 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(srst_i) |-> !px_valid_o && !test_active_o && !wb_ack_o)
    else $error("outputs active after reset");
  a_px_hold: assert property (px_valid_o && !px_ready_i |=> px_valid_o && $stable(px_data_o)
    && $stable(px_last_o)) else $error("pixel changed while stalled");
  a_sensor_drop: assert property (test_active_o && $past(test_active_o) |-> sensor_ready_o)
    else $error("sensor not drained in test mode");
  a_line_start: assert property ($rose(test_active_o) |-> ##[1:12] px_valid_o)
    else $error("no pixel after line start");
  a_pixel_step: assert property (beat && mid_reg && pat_reg inside {3'h1, 3'h2, 3'h3} |->
    px_data_o == ((prev_reg + 12'h001) & (pat_reg == 3'h3 ? 12'hFFF : 12'h0FF)))
    else $error("gradient step wrong");
endmodule : line_tpg_props
bind line_tpg line_tpg_props props (.clock_i(clock_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .px_valid_o(px_valid_o),
  .px_data_o(px_data_o), .px_last_o(px_last_o), .px_ready_i(px_ready_i),
  .sensor_ready_o(sensor_ready_o), .test_active_o(test_active_o));

// File: px_sink.sv
`timescale 1ns/1ps
module px_sink (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic px_valid_i,
  input wire logic [11:0] px_data_i,
  input wire logic px_last_i,
  output logic px_ready_o
);
  logic [12:0] got[$];
  logic [1:0] phase_reg;
  // Slow mode takes one beat in four, so the FIFO fills and the generator waits for room
  assign px_ready_o = !srst_i && (!slow_i || phase_reg == 2'h0);
  always @(posedge clock_i) begin
    phase_reg <= srst_i ? 2'h0 : phase_reg + 2'h1;
    if (px_valid_i && px_ready_o)
      got.push_back({px_last_i, px_data_i});
  end
endmodule : px_sink

// File: line_tpg_test.sv
`timescale 1ns/1ps
`include "line_tpg_defs.svh"
module line_tpg_test;
  logic clock_i, srst_i, cyc, stb, we, trig, ext, s_valid, s_last, slow;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd;
  logic [11:0] s_data, px_data;
  logic [31:0] wb_dat;
  logic ack, s_ready, px_valid, px_last, px_ready, busy;
  int errors, tests_run;
  line_tpg dut (.clock_i(clock_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat),
    .wb_ack_o(ack), .line_trig_i(trig), .ext_trig_i(ext), .sensor_valid_i(s_valid),
    .sensor_data_i(s_data), .sensor_last_i(s_last), .sensor_ready_o(s_ready),
    .px_valid_o(px_valid), .px_data_o(px_data), .px_last_o(px_last), .px_ready_i(px_ready),
    .test_active_o(busy));
  px_sink sink (.clock_i(clock_i), .srst_i(srst_i), .slow_i(slow), .px_valid_i(px_valid),
    .px_data_i(px_data), .px_last_i(px_last), .px_ready_o(px_ready));
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic w);
    @(posedge clock_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    do @(negedge clock_i); while (ack !== 1'b1);
    @(posedge clock_i);
    rd = wb_dat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 32'h0, 4'h0, 1'b0);
    check(rd, exp);
  endtask : rdchk
  task automatic take(input logic [12:0] exp);
    while (sink.got.size() == 0) @(negedge clock_i);
    check({19'h0, sink.got.pop_front()}, {19'h0, exp});
  endtask : take
  task automatic sbeat(input logic [11:0] d, input logic l);
    @(posedge clock_i);
    {s_valid, s_data, s_last} <= {1'b1, d, l};
    do @(negedge clock_i); while (s_ready !== 1'b1);
    @(posedge clock_i);
    s_valid <= 1'b0;
  endtask : sbeat
  task automatic line(input int p, input int cnt, input int src, input bit dbl);
    int v;
    @(posedge clock_i);
    if (src == 1) begin
      ext <= 1'b1;
      repeat (6) @(posedge clock_i);
      ext <= 1'b0;
    end else if (src == 2) begin
      // Soft trigger fires in the cycle after the write lands
      wb(`REG_TRIG_CFG, 32'h2, 4'hF, 1'b1);
      @(posedge clock_i);
    end else begin
      trig <= 1'b1;
      @(posedge clock_i);
      trig <= 1'b0;
    end
    @(negedge clock_i);
    check(busy, 32'h1);
    // Second pulse lands while busy and must not restart the line
    if (dbl) begin
      repeat (3) @(posedge clock_i);
      trig <= 1'b1;
      @(posedge clock_i);
      trig <= 1'b0;
    end
    for (int c = 0; c < 260; c++) begin
      v = (p == 1) ? c % 256 : (p == 2 || p == 4) ? (c + cnt) % 256 : (c + cnt) % 4096;
      if (p > 3)
        v = (v * 384 / 256 > (p == 4 ? 255 : 4095)) ? (p == 4 ? 255 : 4095) : v * 384 / 256;
      take({c == 259, v[11:0]});
    end
  endtask : line
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    errors++;
    report_and_stop();
  end
  initial begin
    {srst_i, cyc, stb, we, trig, ext, s_valid, s_last, slow} = 9'h100;
    {adr, sel, wdat, s_data} = '0;
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    rdchk(`REG_LINE_LEN, 32'h800);
    rdchk(`REG_PATTERN, 32'h0);
    rdchk(`REG_DGAIN, 32'h100);
    rdchk(8'h3C, 32'h0);
    wb(`REG_LINE_LEN, 32'd260, 4'hF, 1'b1);
    wb(`REG_DGAIN, 32'h0001_0180, 4'hF, 1'b1);
    wb(`REG_PATTERN, 32'h7, 4'hF, 1'b1);
    rdchk(`REG_PATTERN, 32'h0);
    slow <= 1'b1;
    // Shading stays off; this block has no shading path to disable
    for (int p = 1; p <= 5; p++) begin
      wb(`REG_PATTERN, p, 4'hF, 1'b1);
      rdchk(`REG_PATTERN, p);
      if (p == 1)
        sbeat(12'h0AB, 1'b1);
      if (p == 3)
        wb(`REG_TRIG_CFG, 32'h1, 4'hF, 1'b1);
      line(p, 0, p == 3, p == 1);
      line(p, 1, p == 3 ? 1 : p == 2 ? 2 : 0, 1'b0);
      wb(`REG_TRIG_CFG, 32'h0, 4'hF, 1'b1);
      wb(`REG_STATUS, 32'h0, 4'h0, 1'b0);
      check(rd & 32'h0F01_0FFF, 32'h2);
    end
    check(rd[17], 32'h1);
    wb(`REG_STATUS, 32'h0002_0000, 4'h4, 1'b1);
    wb(`REG_STATUS, 32'h0, 4'h0, 1'b0);
    check(rd[17], 32'h0);
    rdchk(`REG_LINES, 32'd10);
    wb(`REG_DGAIN, 32'h100, 4'hF, 1'b1);
    wb(`REG_PATTERN, 32'h0, 4'hF, 1'b1);
    sbeat(12'h123, 1'b0);
    sbeat(12'hABC, 1'b1);
    take({1'b0, 12'h123});
    take({1'b1, 12'hABC});
    report_and_stop();
  end
endmodule : line_tpg_test
